// file: rtl/pdcfg_pkg.sv
package pdcfg_pkg;
   localparam int NCH        = 2;
   localparam int FRAME_BITS = 32;
   localparam int CNT_W      = 11;
   localparam int CLK_NS     = 100;
   typedef logic [FRAME_BITS-1:0] pdcfg_frame_t;
   typedef logic [CNT_W-1:0]      pdcfg_cnt_t;
   // frame field positions
   localparam int CMD_HI = 31, CMD_LO = 28, RW_BIT = 27, CFG_HI = 26, CFG_LO = 1;
   localparam int TDIAG_HI = 23, TDIAG_LO = 22, OCREAD_BIT = 21, THR_HI = 20, THR_LO = 15;
   localparam int TEMP_HI = 14, TEMP_LO = 13, SUPPLY_BIT = 12, BLANK_HI = 11, BLANK_LO = 9;
   localparam int REENG_BIT = 8, SENSE_BIT = 7, OLCUR_BIT = 6, GATE_HI = 5, GATE_LO = 4;
   localparam int MOS_BIT = 3, SIDE_BIT = 2, ENOUT_BIT = 1, PARITY_BIT = 0;
   localparam logic [3:0] CMD_CH1 = 4'h1;
   localparam logic [3:0] CMD_CH2 = 4'h2;
   localparam pdcfg_frame_t RESET_CH1 = 32'h1EC00001;
   localparam pdcfg_frame_t RESET_CH2 = 32'h2EC00001;
   localparam pdcfg_frame_t IDLE_REPLY = 32'h00000001;
   // times in ns, thermal limits in degrees and gate currents in mA, as printed
   localparam int BLANK_NS [8] = '{11100, 15600, 20000, 31100, 42200, 53300, 97800, 142200};
   localparam int TDIAG_NS [4] = '{25600, 61200, 105600, 150000};
   localparam logic [6:0] TEMP_DEG [4] = '{7'h00, 7'h3C, 7'h28, 7'h19};
   localparam logic [4:0] GATE_MA  [4] = '{5'h00, 5'h14, 5'h05, 5'h01};

   // least time, rounded up to whole cycles
   function automatic pdcfg_cnt_t ns_to_cycles(input int ns);
      ns_to_cycles = CNT_W'((ns + CLK_NS - 1) / CLK_NS);
   endfunction : ns_to_cycles

   function automatic pdcfg_cnt_t blank_cycles(input logic [2:0] code);
      blank_cycles = ns_to_cycles(BLANK_NS[code]);
   endfunction : blank_cycles

   function automatic pdcfg_cnt_t tdiag_cycles(input logic [1:0] code);
      tdiag_cycles = ns_to_cycles(TDIAG_NS[code]);
   endfunction : tdiag_cycles

   // one when bits 31:1 hold an even count of ones
   function automatic logic frame_parity(input pdcfg_frame_t f);
      frame_parity = ~^f[FRAME_BITS-1:1];
   endfunction : frame_parity
endpackage : pdcfg_pkg

// file: rtl/pdcfg_spi_if.sv
`timescale 1ns/1ns
// frame hand-off between the serial shifter and the register core
interface pdcfg_spi_if;
   import pdcfg_pkg::*;
   pdcfg_frame_t rxFrame;
   logic         rxValid;
   pdcfg_frame_t txFrame;
   modport shifter (output rxFrame, output rxValid, input txFrame);
   modport core    (input rxFrame, input rxValid, output txFrame);
endinterface : pdcfg_spi_if

// file: rtl/pdcfg_spi_shift.sv
`timescale 1ns/1ns
// serial frame shifter: samples mosi on sclk rise, moves miso on sclk fall
module pdcfg_spi_shift
   import pdcfg_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rstN,
   input  wire logic          csN,
   input  wire logic          sclk,
   input  wire logic          mosi,
   output logic               miso,
   pdcfg_spi_if.shifter       link
);
   typedef struct packed {
      logic         sclkPrev;
      logic         csPrev;
      logic [5:0]   count;
      pdcfg_frame_t shIn;
      pdcfg_frame_t shOut;
      logic         miso;
      logic         valid;
   } pdcfg_shift_t;
   pdcfg_shift_t s, next_s;
   localparam logic [5:0] FULL_CNT = 6'(FRAME_BITS);
   localparam logic [5:0] SAT_CNT  = 6'h3F;

   // edge detection, shifting and end-of-frame check
   always_comb begin
      next_s = s;
      next_s.sclkPrev = sclk;
      next_s.csPrev = csN;
      next_s.valid = 1'b0;
      if (s.csPrev && !csN) begin
         next_s.shOut = link.txFrame;
         next_s.miso = link.txFrame[FRAME_BITS-1];
         next_s.count = '0;
      end else if (!csN && sclk && !s.sclkPrev) begin
         next_s.shIn = {s.shIn[FRAME_BITS-2:0], mosi};
         if (s.count != SAT_CNT) next_s.count = s.count + 6'h01;
      end else if (!csN && !sclk && s.sclkPrev) begin
         next_s.shOut = {s.shOut[FRAME_BITS-2:0], 1'b0};
         next_s.miso = s.shOut[FRAME_BITS-2];
      end
      if (!s.csPrev && csN) next_s.valid = (s.count == FULL_CNT);
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s <= '0;
         s.csPrev <= 1'b1; // idle level of the select, no false frame end
      end else begin
         s <= next_s;
      end
   end

   assign link.rxFrame = s.shIn;
   assign link.rxValid = s.valid;
   assign miso         = s.miso;
endmodule : pdcfg_spi_shift

// file: rtl/pdcfg_interval_timer.sv
`timescale 1ns/1ns
// one-shot interval timer; expired rises a programmed count after start
module pdcfg_interval_timer
   import pdcfg_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstN,
   input  wire logic       start,
   input  pdcfg_pkg::pdcfg_cnt_t cycles,
   output logic            expired
);
   typedef struct packed {
      pdcfg_cnt_t count;
      logic       done;
   } pdcfg_timer_t;
   pdcfg_timer_t s, next_s;
   localparam pdcfg_cnt_t ONE = CNT_W'(1);

   // restart on start, count down, hold done
   always_comb begin
      next_s = s;
      if (start) begin
         next_s.count = cycles;
         next_s.done = 1'b0;
      end else if (s.count != '0) begin
         next_s.count = s.count - ONE;
         if (s.count == ONE) next_s.done = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) s <= '0;
      else s <= next_s;
   end

   assign expired = s.done;
endmodule : pdcfg_interval_timer

// file: rtl/pdcfg_top.sv
`timescale 1ns/1ns
// channel 1 and 2 configuration words of the pre-driver with
// overcurrent blanking, re-engagement and off-state filter timing
module pdcfg_top
   import pdcfg_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     spiCsN,
   input  wire logic                     spiSclk,
   input  wire logic                     spiMosi,
   output logic                          spiMiso,
   output logic                          spiMisoOe,
   input  wire logic [pdcfg_pkg::NCH-1:0] chCtrl,
   input  wire logic [pdcfg_pkg::NCH-1:0] ocRaw,
   input  wire logic [pdcfg_pkg::NCH-1:0][5:0] actualThreshold,
   output logic [pdcfg_pkg::NCH-1:0]     gateOn,
   output logic [pdcfg_pkg::NCH-1:0]     ocShutdown,
   output logic [pdcfg_pkg::NCH-1:0]     noOcFailure,
   output logic [pdcfg_pkg::NCH-1:0]     offDiagReady,
   output logic [pdcfg_pkg::NCH-1:0]     sideHigh,
   output logic [pdcfg_pkg::NCH-1:0]     mosOption,
   output logic [pdcfg_pkg::NCH-1:0]     senseShunt,
   output logic [pdcfg_pkg::NCH-1:0]     openloadHighCurrent,
   output logic [pdcfg_pkg::NCH-1:0]     supplyAdjustOn,
   output logic [pdcfg_pkg::NCH-1:0][6:0] thermalLimitDeg,
   output logic [pdcfg_pkg::NCH-1:0][4:0] gateCurrentMa,
   output logic [pdcfg_pkg::NCH-1:0][5:0] thresholdCode
);
   import pdcfg_pkg::*;

   typedef struct packed {
      logic [NCH-1:0][FRAME_BITS-1:0] setup;
      pdcfg_frame_t                   tx;
      logic [NCH-1:0]                 ocLatch;
      logic [NCH-1:0]                 readout;
      logic [NCH-1:0]                 ctrlPrev;
      logic [NCH-1:0]                 gate;
      logic [NCH-1:0]                 noOc;
      logic [NCH-1:0]                 offReady;
   } pdcfg_core_t;

   pdcfg_core_t    s, next_s;
   logic [1:0]     rstSync;
   logic           rstN;
   logic [NCH-1:0] blankExpired;
   logic [NCH-1:0] offExpired;
   logic [NCH-1:0] blankStart;
   logic [NCH-1:0] offStart;
   pdcfg_spi_if    link ();

   // command nibble to channel index, one when it names a channel here
   function automatic logic cmd_hit(input logic [3:0] cmd);
      cmd_hit = (cmd == CMD_CH1) || (cmd == CMD_CH2);
   endfunction : cmd_hit

   function automatic logic cmd_index(input logic [3:0] cmd);
      cmd_index = (cmd == CMD_CH2);
   endfunction : cmd_index

   // reset release through two flops; covers power-on and the external reset input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) rstSync <= '0;
      else rstSync <= {rstSync[0], 1'b1};
   end
   assign rstN = rstSync[1];

   pdcfg_spi_shift u_shift (
      .clk  (clk),
      .rstN (rstN),
      .csN  (spiCsN),
      .sclk (spiSclk),
      .mosi (spiMosi),
      .miso (spiMiso),
      .link (link.shifter)
   );

   // per channel blanking and off-state filter timers
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         // blanking restarts on each enabled turn-on edge
         assign blankStart[g] = chCtrl[g] && !s.ctrlPrev[g] && s.setup[g][ENOUT_BIT];
         // off filter restarts on each turn-off edge
         assign offStart[g] = !chCtrl[g] && s.ctrlPrev[g];

         pdcfg_interval_timer u_blank (
            .clk     (clk),
            .rstN    (rstN),
            .start   (blankStart[g]),
            .cycles  (blank_cycles(s.setup[g][BLANK_HI:BLANK_LO])),
            .expired (blankExpired[g])
         );

         pdcfg_interval_timer u_off (
            .clk     (clk),
            .rstN    (rstN),
            .start   (offStart[g]),
            .cycles  (tdiag_cycles(s.setup[g][TDIAG_HI:TDIAG_LO])),
            .expired (offExpired[g])
         );
      end
   endgenerate

   // frame decode, configuration update, protection and reply build
   always_comb begin
      logic         frameOk;
      logic         hit;
      logic         idx;
      logic [3:0]   cmd;
      logic         rise;
      logic         trip;
      logic         clearOk;
      pdcfg_frame_t reply;
      next_s = s;
      frameOk = link.rxValid && (link.rxFrame[PARITY_BIT] == frame_parity(link.rxFrame));
      cmd = link.rxFrame[CMD_HI:CMD_LO];
      hit = frameOk && cmd_hit(cmd);
      idx = cmd_index(cmd);
      rise = 1'b0;
      trip = 1'b0;
      clearOk = 1'b0;
      reply = IDLE_REPLY;

      // write only on a whole, good-parity frame with write access
      if (hit && !link.rxFrame[RW_BIT]) begin
         next_s.setup[idx][CFG_HI:CFG_LO] = link.rxFrame[CFG_HI:CFG_LO];
      end

      // overcurrent latch and re-engagement per channel
      for (int i = 0; i < NCH; i++) begin
         rise = chCtrl[i] && !s.ctrlPrev[i];
         next_s.ctrlPrev[i] = chCtrl[i];
         if (s.setup[i][SENSE_BIT]) begin
            trip = ocRaw[i] && s.gate[i];
         end else begin
            trip = ocRaw[i] && s.gate[i] && blankExpired[i];
         end
         if (s.setup[i][REENG_BIT]) begin
            clearOk = rise && s.readout[i];
         end else begin
            clearOk = rise;
         end
         // an access to the channel word counts as diagnostic readout
         if (hit && (idx == 1'(i)) && s.ocLatch[i]) next_s.readout[i] = 1'b1;
         if (clearOk) begin
            next_s.ocLatch[i] = 1'b0;
            next_s.readout[i] = 1'b0;
         end
         // a new trip wins over a clear in the same cycle
         if (trip) begin
            next_s.ocLatch[i] = 1'b1;
            next_s.readout[i] = 1'b0;
         end
         next_s.gate[i] = s.setup[i][ENOUT_BIT] && chCtrl[i] && !next_s.ocLatch[i];
         next_s.noOc[i] = s.gate[i] && blankExpired[i] && !s.ocLatch[i];
         next_s.offReady[i] = !chCtrl[i] && offExpired[i];
      end

      // reply goes out in the next frame
      if (frameOk) begin
         if (hit) begin
            reply = next_s.setup[idx];
            if (next_s.setup[idx][OCREAD_BIT]) begin
               reply[THR_HI:THR_LO] = actualThreshold[idx];
            end
         end
         reply[CMD_HI:CMD_LO] = cmd;
         reply[RW_BIT] = link.rxFrame[RW_BIT];
         reply[PARITY_BIT] = frame_parity(reply);
         next_s.tx = reply;
      end
   end

   // configuration and state register, reset to documented values
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s <= '0;
         s.setup[0] <= RESET_CH1;
         s.setup[1] <= RESET_CH2;
         s.tx <= IDLE_REPLY;
      end else begin
         s <= next_s;
      end
   end

   assign link.txFrame = s.tx;
   assign spiMisoOe    = !spiCsN;

   // field outputs from the stored words, thermal limit and gate current through the lookup tables
   generate
      for (g = 0; g < NCH; g++) begin : g_out
         assign gateOn[g]              = s.gate[g];
         assign ocShutdown[g]          = s.ocLatch[g];
         assign noOcFailure[g]         = s.noOc[g];
         assign offDiagReady[g]        = s.offReady[g];
         assign sideHigh[g]            = s.setup[g][SIDE_BIT];
         assign mosOption[g]           = s.setup[g][MOS_BIT];
         assign senseShunt[g]          = s.setup[g][SENSE_BIT];
         assign openloadHighCurrent[g] = s.setup[g][OLCUR_BIT];
         assign supplyAdjustOn[g]      = s.setup[g][SUPPLY_BIT];
         assign thermalLimitDeg[g]     = TEMP_DEG[s.setup[g][TEMP_HI:TEMP_LO]];
         assign gateCurrentMa[g]       = GATE_MA[s.setup[g][GATE_HI:GATE_LO]];
         assign thresholdCode[g]       = s.setup[g][THR_HI:THR_LO];
      end
   endgenerate
endmodule : pdcfg_top

// file: verification/pdcfg_top_asserts.sv
`timescale 1ns/1ns
// protection and frame timing seen at the top ports
module pdcfg_top_asserts (
   input wire logic                             clk,
   input wire logic                             rst_n,
   input wire logic                             spiCsN,
   input wire logic                             spiMisoOe,
   input wire logic [pdcfg_pkg::NCH-1:0]        chCtrl,
   input wire logic [pdcfg_pkg::NCH-1:0]        ocRaw,
   input wire logic [pdcfg_pkg::NCH-1:0]        gateOn,
   input wire logic [pdcfg_pkg::NCH-1:0]        ocShutdown,
   input wire logic [pdcfg_pkg::NCH-1:0]        noOcFailure,
   input wire logic [pdcfg_pkg::NCH-1:0]        offDiagReady,
   input wire logic [pdcfg_pkg::NCH-1:0]        senseShunt,
   input wire logic [pdcfg_pkg::NCH-1:0][5:0]   thresholdCode
);
   import pdcfg_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // channel 1 protection, frame boundaries
   a_reset_clean: assert property (
      $rose(rst_n) |-> gateOn == '0 && ocShutdown == '0 && thresholdCode == '0)
      else $error("outputs not at reset values");
   a_fields_steady: assert property (
      !spiCsN && !$past(spiCsN) |-> $stable(thresholdCode))
      else $error("field changed inside a frame");
   a_gate_follows: assert property (
      gateOn[0] |-> $past(chCtrl[0]))
      else $error("gate on without control");
   a_shunt_trip: assert property (
      gateOn[0] && ocRaw[0] && senseShunt[0] |-> ##[1:3] ocShutdown[0])
      else $error("shunt overcurrent not latched");
   a_latched_off: assert property (
      ocShutdown[0] |-> !gateOn[0])
      else $error("gate on while latched");
   a_dsm_blank: assert property (
      $rose(gateOn[0]) && !senseShunt[0] |-> !ocShutdown[0] [*8])
      else $error("trip inside blanking");
   a_nofail_wait: assert property (
      $rose(noOcFailure[0]) |-> $past(gateOn[0], 100))
      else $error("no-failure code too early");
   a_offdiag_wait: assert property (
      $rose(offDiagReady[0]) |-> !$past(chCtrl[0], 200))
      else $error("off filter too short");
   a_miso_drive: assert property (
      spiMisoOe == !spiCsN)
      else $error("data out driven outside frame");
   c_trip: cover property ($rose(ocShutdown[0]));
   c_nofail: cover property ($rose(noOcFailure[0]));
   c_offdiag: cover property ($rose(offDiagReady[0]));
endmodule : pdcfg_top_asserts

// file: verification/pdcfg_host_model.sv
`timescale 1ns/1ns
// host side: 32-bit frames msb first, reply collected on each rise
module pdcfg_host_model (
   input  wire logic              clk,
   input  wire logic              miso,
   output logic                   csN,
   output logic                   sclk,
   output logic                   mosi,
   output logic                   replyValid,
   output pdcfg_pkg::pdcfg_frame_t reply
);
   import pdcfg_pkg::*;
   logic busy = 1'b0;
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
      replyValid = 1'b0;
      reply = '0;
   end
   // idle data line keeps changing, so no stale bit looks valid
   always @(posedge clk) begin
      if (!busy) mosi <= ~mosi;
   end
   // one frame; bad flips the parity bit
   task automatic xfer(input pdcfg_frame_t f, input logic bad);
      busy = 1'b1;
      f[0] = bad ^ ~^f[31:1];
      @(posedge clk);
      csN <= 1'b0;
      for (int i = 31; i >= 0; i--) begin
         mosi <= f[i];
         repeat (2) @(posedge clk);
         reply[i] <= miso;
         sclk <= 1'b1;
         repeat (3) @(posedge clk);
         sclk <= 1'b0;
         @(posedge clk);
      end
      repeat (2) @(posedge clk);
      csN <= 1'b1;
      repeat (5) @(posedge clk);
      replyValid <= 1'b1;
      busy = 1'b0;
      @(posedge clk);
      replyValid <= 1'b0;
   endtask : xfer
endmodule : pdcfg_host_model

// file: verification/pdcfg_top_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin #1; numChecks++; if ((g) !== (e)) begin errTotal++; \
   $display("unexpected %s expected %h seen %h", n, e, g); end end
// configuration words over the serial port, then channel 1 protection
module pdcfg_top_tb;
   import pdcfg_pkg::*;
   logic clk, rst_n, spiCsN, spiSclk, spiMosi, spiMiso, spiMisoOe, replyValid;
   logic [NCH-1:0] chCtrl, ocRaw, gateOn, ocShutdown, noOcFailure, offDiagReady, sideHigh;
   logic [NCH-1:0] mosOption, senseShunt, openloadHighCurrent, supplyAdjustOn;
   logic [NCH-1:0][5:0] actualThreshold, thresholdCode;
   logic [NCH-1:0][6:0] thermalLimitDeg;
   logic [NCH-1:0][4:0] gateCurrentMa;
   pdcfg_frame_t reply, lastExp, expQ[$];
   logic [26:1] cfg [NCH];
   logic [26:1] w;
   int errTotal = 0;
   int numChecks = 0;
   pdcfg_top DUT (.clk, .rst_n, .spiCsN, .spiSclk, .spiMosi, .spiMiso, .spiMisoOe,
      .chCtrl, .ocRaw, .actualThreshold, .gateOn, .ocShutdown, .noOcFailure, .offDiagReady,
      .sideHigh, .mosOption, .senseShunt, .openloadHighCurrent, .supplyAdjustOn,
      .thermalLimitDeg, .gateCurrentMa, .thresholdCode);
   pdcfg_host_model HOST (.clk, .miso(spiMiso), .csN(spiCsN), .sclk(spiSclk),
      .mosi(spiMosi), .replyValid, .reply);
   always #50 clk = ~clk;
   // each reply against the oldest note; parity checked on its own
   always @(posedge clk) begin
      if (replyValid) begin
         `CHK("reply", expQ[0] & 32'hFFFFFFFE, reply & 32'hFFFFFFFE)
         `CHK("parity", ~^reply[31:1], reply[0])
         `CHK("misoOe", 1'b0, spiMisoOe)
         expQ.delete(0);
      end
   end
   task automatic stopTest;
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stopTest
   // one frame; note the reply the next frame brings back
   task automatic send(input logic [3:0] cmd, input logic rw, input logic [26:1] d,
                       input logic bad);
      int c;
      c = (cmd == CMD_CH2);
      expQ.push_back(lastExp);
      HOST.xfer({cmd, rw, d, 1'b0}, bad);
      if (!bad && cmd inside {CMD_CH1, CMD_CH2}) begin
         if (!rw) cfg[c] = d;
         lastExp = {cmd, rw, cfg[c], 1'b0};
         if (cfg[c][OCREAD_BIT]) lastExp[THR_HI:THR_LO] = actualThreshold[c];
      end else if (!bad) lastExp = {cmd, rw, 26'h0, 1'b0};
   endtask : send
   task automatic checkFields(input int c);
      `CHK("thermal", TEMP_DEG[cfg[c][TEMP_HI:TEMP_LO]], thermalLimitDeg[c])
      `CHK("supply", cfg[c][SUPPLY_BIT], supplyAdjustOn[c])
      `CHK("sense", cfg[c][SENSE_BIT], senseShunt[c])
      `CHK("olcur", cfg[c][OLCUR_BIT], openloadHighCurrent[c])
      `CHK("gate", GATE_MA[cfg[c][GATE_HI:GATE_LO]], gateCurrentMa[c])
      `CHK("mos", cfg[c][MOS_BIT], mosOption[c])
      `CHK("side", cfg[c][SIDE_BIT], sideHigh[c])
      `CHK("thr", cfg[c][THR_HI:THR_LO], thresholdCode[c])
   endtask : checkFields
   task automatic toggle;
      @(posedge clk);
      chCtrl[0] <= 1'b0;
      repeat (3) @(posedge clk);
      chCtrl[0] <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : toggle
   // trip on shunt, then try to re-engage
   task automatic reengage(input logic policy);
      chCtrl[0] <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("gateOn", 1'b1, gateOn[0])
      @(posedge clk);
      ocRaw[0] <= 1'b1;
      repeat (2) @(posedge clk);
      ocRaw[0] <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("shutdown", 1'b1, ocShutdown[0])
      toggle();
      `CHK("held", policy, ocShutdown[0])
      if (policy) begin
         send(CMD_CH1, 1'b1, 26'h0, 1'b0);
         toggle();
         `CHK("cleared", 1'b0, ocShutdown[0])
      end
      @(posedge clk);
      chCtrl[0] <= 1'b0;
      @(posedge clk);
   endtask : reengage
   initial begin
      repeat (20000) @(posedge clk);
      errTotal++;
      stopTest();
   end
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      chCtrl = '0;
      ocRaw = '0;
      actualThreshold = '0;
      lastExp = IDLE_REPLY;
      cfg[0] = RESET_CH1[26:1];
      cfg[1] = RESET_CH2[26:1];
      void'($urandom(32'h2D6B));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      actualThreshold <= 12'($urandom);
      repeat (4) @(posedge clk);
      checkFields(0);
      checkFields(1);
      // every thermal and gate code on both channels, output kept off
      for (int i = 0; i < 8; i++) begin
         w = 26'($urandom);
         w[TEMP_HI:TEMP_LO] = 2'(i >> 1);
         w[GATE_HI:GATE_LO] = 2'(i >> 1);
         w[OCREAD_BIT] = i[2];
         w[ENOUT_BIT] = 1'b0;
         send(i[0] ? CMD_CH2 : CMD_CH1, 1'b0, w, 1'b0);
         checkFields(i[0]);
      end
      // bad parity, read only and unknown command leave fields alone
      send(CMD_CH1, 1'b0, ~cfg[0], 1'b1);
      checkFields(0);
      send(CMD_CH2, 1'b1, ~cfg[1], 1'b0);
      checkFields(1);
      send(4'h3, 1'b0, 26'h3FFFFFF, 1'b0);
      checkFields(0);
      checkFields(1);
      for (int p = 0; p < 2; p++) begin
         w = '0;
         w[ENOUT_BIT] = 1'b1;
         w[SENSE_BIT] = 1'b1;
         w[REENG_BIT] = p[0];
         send(CMD_CH1, 1'b0, w, 1'b0);
         reengage(p[0]);
      end
      // mid-run reset puts both written words back
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      cfg[0] = RESET_CH1[26:1];
      cfg[1] = RESET_CH2[26:1];
      lastExp = IDLE_REPLY;
      repeat (4) @(posedge clk);
      checkFields(0);
      checkFields(1);
      // drain-source sensing: shortest blanking and off filter
      w[SENSE_BIT] = 1'b0;
      w[REENG_BIT] = 1'b0;
      send(CMD_CH1, 1'b0, w, 1'b0);
      chCtrl[0] <= 1'b1;
      ocRaw[0] <= 1'b1;
      repeat (60) @(posedge clk);
      ocRaw[0] <= 1'b0;
      `CHK("early", 1'b0, noOcFailure[0])
      `CHK("blanked", 1'b0, ocShutdown[0])
      repeat (60) @(posedge clk);
      `CHK("noOcFail", 1'b1, noOcFailure[0])
      @(posedge clk);
      chCtrl[0] <= 1'b0;
      repeat (262) @(posedge clk);
      `CHK("offDiag", 1'b1, offDiagReady[0])
      stopTest();
   end
endmodule : pdcfg_top_tb
bind pdcfg_top pdcfg_top_asserts ASSERTS (.clk, .rst_n, .spiCsN, .spiMisoOe, .chCtrl, .ocRaw,
   .gateOn, .ocShutdown, .noOcFailure, .offDiagReady, .senseShunt, .thresholdCode);
